// >>> token_net_pkg.sv
// constants, register layout and state encodings for the token network controller
// assumes every pin-side input is synchronised before the core logic reads it
package token_net_pkg;

  // register select codes
  localparam logic [3:0] REG_CR0  = 4'h0;
  localparam logic [3:0] REG_CR1  = 4'h1;
  localparam logic [3:0] REG_FIRST_STATUS = 4'h2;
  localparam logic [3:0] REG_IR0  = 4'h3;
  localparam logic [3:0] REG_SR1  = 4'h4;
  localparam logic [3:0] REG_SR2  = 4'h5;
  localparam logic [3:0] REG_CTR0 = 4'h6;
  localparam logic [3:0] REG_NA   = 4'h7;
  localparam logic [3:0] REG_CBPH = 4'ha;
  localparam logic [3:0] REG_CBPL = 4'hb;
  localparam logic [3:0] REG_TXLT = 4'he;
  localparam logic [3:0] REG_MA   = 4'hf;

  // control register 0 bit positions
  localparam int CR0_ISOLATE = 0;
  localparam int CR0_NOINT   = 1;
  localparam int CR0_COPY    = 2;
  localparam int CR0_RXEN    = 5;
  localparam int CR0_TXEN    = 6;

  // interrupt event bit positions
  localparam int IR_STATE = 0;
  localparam int IR_REC   = 3;
  localparam int IR_TRAN  = 4;
  localparam int IR_ROR   = 6;

  // status bit positions
  localparam int SR1_RTS     = 6;
  localparam int SR1_RECIDLE = 5;
  localparam int SR2_TR      = 5;
  localparam int SR2_STATE   = 1;
  localparam int SR2_INRING  = 0;

  // reset values
  localparam logic [7:0] CR0_RESET   = 8'h01;
  localparam logic [7:0] OTHER_RESET = 8'h00;
  localparam logic [7:0] SR1_ONES    = 8'h1f;

  // framing
  localparam logic [7:0]  FLAG_PATTERN   = 8'h7e;
  localparam logic [7:0]  BROADCAST_ADDR = 8'hff;
  localparam logic [2:0]  STUFF_ONES     = 3'd5;
  localparam logic [2:0]  ABORT_ONES     = 3'd6;
  localparam logic [2:0]  LAST_BIT       = 3'd7;
  localparam logic [15:0] TX_AREA_OFFSET = 16'h0100;

  // synchroniser lanes
  localparam int SY_DATA = 0;
  localparam int SY_SEL  = 8;
  localparam int SY_RXC  = 12;
  localparam int SY_RXD  = 13;
  localparam int SY_TXC  = 14;
  localparam int SY_CTS  = 15;
  localparam int SY_QUAL  = 16;
  localparam int SY_ACK   = 17;
  localparam int SY_CS    = 18;
  localparam int SY_RD    = 19;
  localparam int SY_WE    = 20;
  localparam int SY_RESET = 21;
  localparam int SYNC_W  = 22;

  typedef enum logic [2:0] {
    TX_IDLE  = 3'b000,
    TX_FETCH = 3'b001,
    TX_CTS   = 3'b010,
    TX_FLAG1 = 3'b011,
    TX_DATA  = 3'b100,
    TX_FLAG2 = 3'b101
  } tx_state_type;

endpackage : token_net_pkg

// >>> pin_sync.sv
// two-stage synchroniser with edge detection for a vector of pin inputs
// assumes the inputs are asynchronous to i_core_clk
`timescale 1ns/1ps
`default_nettype none
module pin_sync
  import token_net_pkg::*;
(
  // clock and reset
  input  wire logic              i_core_clk,
  input  wire logic              i_rst,
  // pins
  input  wire logic [SYNC_W-1:0] i_pins,
  // synchronised view
  output logic      [SYNC_W-1:0] o_level,
  output logic      [SYNC_W-1:0] o_rise,
  output logic      [SYNC_W-1:0] o_fall
);
  genvar g;
  generate
    for (g = 0; g < SYNC_W; g++) begin : g_lane
      logic meta_reg;
      logic stable_reg;
      logic prev_reg;
      always_ff @(posedge i_core_clk) begin
        if (i_rst) begin
          meta_reg   <= 1'b1;
          stable_reg <= 1'b1;
          prev_reg   <= 1'b1;
        end else begin
          meta_reg   <= i_pins[g];
          stable_reg <= meta_reg;
          prev_reg   <= stable_reg;
        end
      end
      assign o_level[g] = stable_reg;
      assign o_rise[g]  = stable_reg & ~prev_reg;
      assign o_fall[g]  = ~stable_reg & prev_reg;
    end
  endgenerate
endmodule : pin_sync
`default_nettype wire

// >>> token_net_controller.sv
// pin interface of the token network controller: host register port, dual dma, modem link
// assumes all pins are asynchronous to i_core_clk; link clocks are far slower than the core clock
`timescale 1ns/1ps
`default_nettype none
module token_net_controller
  import token_net_pkg::*;
(
  // clock and reset
  input  wire logic        i_core_clk,
  input  wire logic        i_rst,
  input  wire logic        i_master_reset_n,
  // host register port
  input  wire logic        i_chip_select_n,
  input  wire logic        i_read_strobe_n,
  input  wire logic        i_write_strobe_n,
  input  wire logic [3:0]  i_register_select_in,
  input  wire logic [7:0]  i_shared_data_lines,
  output logic      [7:0]  o_shared_data_lines,
  output logic             o_shared_data_lines_oe_n,
  output logic             o_interrupt_request_n,
  // dma
  output logic             o_dma_out_request_n,
  output logic             o_dma_in_request_n,
  input  wire logic        i_dma_acknowledge_n,
  output logic      [15:0] o_dma_address_out,
  // modem link
  input  wire logic        i_serial_rx_clock,
  input  wire logic        i_serial_rx_data,
  input  wire logic        i_serial_tx_clock_n,
  output logic             o_serial_tx_data,
  output logic             o_tx_request_n,
  output logic             o_tx_request_oe_n,
  input  wire logic        i_clear_to_send_n,
  input  wire logic        i_signal_quality_n
);
  import token_net_pkg::*;

  typedef struct packed {
    logic [15:0][7:0] regs;
    logic             wr_act;
    logic [7:0]       wr_data;
    logic [3:0]       wr_sel;
    logic             rd_act;
    logic [3:0]       rd_sel;
    logic             net_mode;
    logic [7:0]       rx_win;
    logic [2:0]       rx_ones;
    logic [2:0]       rx_bits;
    logic [7:0]       rx_sh;
    logic             rx_in_frame;
    logic             rx_first;
    logic             rx_match;
    logic             rx_bad;
    logic             rx_got;
    logic [7:0]       rx_hold;
    logic             rx_hold_valid;
    logic [15:0]      rx_addr;
    tx_state_type     tx_state;
    logic             tx_go;
    logic [7:0]       tx_sh;
    logic [2:0]       tx_bits;
    logic [2:0]       tx_ones;
    logic [7:0]       tx_fetch_left;
    logic [7:0]       tx_hold;
    logic             tx_hold_valid;
    logic [15:0]      tx_addr;
    logic             tx_bit;
    logic             rts_n;
    logic             dma_act;
    logic             dma_out;
    logic             drq_out_n;
    logic             drq_in_n;
    logic [15:0]      addr_out;
    logic [7:0]       data_out;
    logic             data_oe_n;
    logic             irq_n;
  } state_type;

  state_type state_reg;
  state_type state_next;

  logic [SYNC_W-1:0] pins;
  logic [SYNC_W-1:0] lv;
  logic [SYNC_W-1:0] rise;
  logic [SYNC_W-1:0] fall;

  assign pins = {i_master_reset_n, i_write_strobe_n, i_read_strobe_n, i_chip_select_n,
                 i_dma_acknowledge_n, i_signal_quality_n, i_clear_to_send_n, i_serial_tx_clock_n,
                 i_serial_rx_data, i_serial_rx_clock, i_register_select_in, i_shared_data_lines};

  pin_sync u_pin_sync (
    .i_core_clk (i_core_clk),
    .i_rst      (i_rst),
    .i_pins     (pins),
    .o_level    (lv),
    .o_rise     (rise),
    .o_fall     (fall)
  );

  // SR1 and SR2 are composed live from block state
  function automatic logic [7:0] reg_view(input state_type s, input logic [3:0] sel);
    logic [7:0] v;
    v = s.regs[sel];
    case (sel)
      REG_SR1: begin
        v = SR1_ONES;
        v[SR1_RTS]     = s.rts_n;
        v[SR1_RECIDLE] = ~s.rx_in_frame;
      end
      REG_SR2: begin
        v = OTHER_RESET;
        v[SR2_TR]     = (s.tx_state != TX_IDLE);
        v[SR2_STATE]  = ~s.net_mode;
        v[SR2_INRING] = s.net_mode;
      end
      default: v = s.regs[sel];
    endcase
    return v;
  endfunction : reg_view

  function automatic logic host_writable(input logic [3:0] sel);
    return (sel < REG_FIRST_STATUS) || (sel > REG_NA);
  endfunction : host_writable

  always_comb begin
    logic       wr_now;
    logic       rd_now;
    logic       rx_b;
    logic [7:0] win;
    logic [7:0] byte_v;
    logic [7:0] ir_set;
    logic       ir_clear;
    wr_now   = ~lv[SY_CS] & ~lv[SY_WE];
    rd_now   = ~lv[SY_CS] & ~lv[SY_RD];
    rx_b     = lv[SY_RXD];
    win      = {rx_b, state_reg.rx_win[7:1]};
    byte_v   = {rx_b, state_reg.rx_sh[7:1]};
    ir_set   = OTHER_RESET;
    ir_clear = 1'b0;
    state_next = state_reg;

    // host register port: data is captured while the strobe is low, committed at its release
    state_next.wr_act = wr_now;
    state_next.rd_act = rd_now;
    if (wr_now) begin
      state_next.wr_data = lv[SY_DATA +: 8];
      state_next.wr_sel  = lv[SY_SEL +: 4];
    end
    if (rd_now) begin
      state_next.rd_sel = lv[SY_SEL +: 4];
    end
    if (state_reg.wr_act && !wr_now && host_writable(state_reg.wr_sel)) begin
      state_next.regs[state_reg.wr_sel] = state_reg.wr_data;
      if (state_reg.wr_sel == REG_TXLT && state_reg.wr_data != OTHER_RESET) begin
        state_next.tx_go = 1'b1;
      end
    end
    if (state_reg.rd_act && !rd_now && state_reg.rd_sel == REG_IR0) begin
      ir_clear = 1'b1;
    end

    // mode change waits for the transmitter so a frame in flight ends cleanly
    if (state_reg.tx_state == TX_IDLE) begin
      if (!state_reg.net_mode && !state_reg.regs[REG_CR0][CR0_ISOLATE]) begin
        state_next.net_mode      = 1'b1;
        state_next.regs[REG_FIRST_STATUS] = OTHER_RESET;
        state_next.rx_addr       = {state_reg.regs[REG_CBPH], state_reg.regs[REG_CBPL]};
        state_next.tx_addr       = {state_reg.regs[REG_CBPH], state_reg.regs[REG_CBPL]} + TX_AREA_OFFSET;
        ir_set[IR_STATE]         = 1'b1;
      end else if (state_reg.net_mode && state_reg.regs[REG_CR0][CR0_ISOLATE]) begin
        state_next.net_mode = 1'b0;
        ir_set[IR_STATE]    = 1'b1;
      end
    end

    // receiver: flag hunt, zero-bit removal, address filter
    if (rise[SY_RXC]) begin
      state_next.rx_win = win;
      if (lv[SY_QUAL]) begin
        state_next.rx_bad = 1'b1;
      end
      if (win == FLAG_PATTERN) begin
        if (state_reg.rx_in_frame && state_reg.rx_got && state_reg.rx_bits == LAST_BIT) begin
          if (!state_reg.rx_bad && !lv[SY_QUAL] && state_reg.rx_match) begin
            ir_set[IR_REC] = 1'b1;
          end else if (state_reg.rx_bad || lv[SY_QUAL]) begin
            state_next.regs[REG_CTR0] = state_reg.regs[REG_CTR0] + 8'h01;
          end
        end
        state_next.rx_in_frame = 1'b1;
        state_next.rx_first    = 1'b1;
        state_next.rx_match    = 1'b0;
        state_next.rx_bad      = 1'b0;
        state_next.rx_got      = 1'b0;
        state_next.rx_bits     = 3'd0;
        state_next.rx_ones     = 3'd0;
      end else if (state_reg.rx_in_frame) begin
        if (rx_b && state_reg.rx_ones == ABORT_ONES) begin
          state_next.rx_in_frame = 1'b0;
        end else if (!rx_b && state_reg.rx_ones == STUFF_ONES) begin
          state_next.rx_ones = 3'd0;
        end else begin
          state_next.rx_ones = rx_b ? state_reg.rx_ones + 3'd1 : 3'd0;
          state_next.rx_sh   = byte_v;
          state_next.rx_bits = state_reg.rx_bits + 3'd1;
          if (state_reg.rx_bits == LAST_BIT) begin
            state_next.rx_first = 1'b0;
            state_next.rx_got   = 1'b1;
            if (state_reg.rx_first) begin
              // 0 and 255 are not station numbers, leaving 254 nodes plus broadcast
              state_next.rx_match = (byte_v == state_reg.regs[REG_MA] && byte_v != OTHER_RESET)
                                  || byte_v == BROADCAST_ADDR
                                  || state_reg.regs[REG_CR0][CR0_COPY];
            end
            if ((state_reg.rx_first ? state_next.rx_match : state_reg.rx_match)
                && state_reg.net_mode && state_reg.regs[REG_CR0][CR0_RXEN]) begin
              if (state_reg.rx_hold_valid) begin
                ir_set[IR_ROR] = 1'b1;
              end else begin
                state_next.rx_hold       = byte_v;
                state_next.rx_hold_valid = 1'b1;
              end
            end
          end
        end
      end
    end

    // transmitter sequencing
    case (state_reg.tx_state)
      TX_IDLE: begin
        state_next.rts_n = 1'b1;
        if (state_reg.tx_go && state_reg.net_mode && state_reg.regs[REG_CR0][CR0_TXEN]) begin
          state_next.tx_go         = state_reg.wr_act && !wr_now && state_reg.wr_sel == REG_TXLT
                                     && state_reg.wr_data != OTHER_RESET;
          state_next.tx_fetch_left = state_reg.regs[REG_TXLT];
          state_next.tx_state      = TX_FETCH;
        end
      end
      TX_FETCH: begin
        if (state_reg.tx_hold_valid) begin
          state_next.rts_n    = 1'b0;
          state_next.tx_state = TX_CTS;
        end
      end
      TX_CTS: begin
        if (!lv[SY_CTS]) begin
          state_next.tx_state = TX_FLAG1;
          state_next.tx_sh    = FLAG_PATTERN;
          state_next.tx_bits  = 3'd0;
        end
      end
      TX_FLAG1, TX_DATA, TX_FLAG2: begin
        if (fall[SY_TXC]) begin
          if (state_reg.tx_state == TX_FLAG2 && state_reg.tx_sh == OTHER_RESET && state_reg.tx_bits == 3'd0) begin
            // closing flag fully shifted: its last bit has had a whole clock period
            state_next.tx_state = TX_IDLE;
            state_next.rts_n    = 1'b1;
            state_next.tx_bit   = 1'b1;
            ir_set[IR_TRAN]     = 1'b1;
          end else if (state_reg.tx_state == TX_DATA && state_reg.tx_ones == STUFF_ONES) begin
            state_next.tx_bit  = 1'b0;
            state_next.tx_ones = 3'd0;
          end else begin
            state_next.tx_bit  = state_reg.tx_sh[0];
            state_next.tx_sh   = {1'b0, state_reg.tx_sh[7:1]};
            state_next.tx_ones = state_reg.tx_sh[0] ? state_reg.tx_ones + 3'd1 : 3'd0;
            state_next.tx_bits = state_reg.tx_bits + 3'd1;
            if (state_reg.tx_bits == LAST_BIT) begin
              state_next.tx_ones = state_reg.tx_state == TX_DATA && state_reg.tx_sh[0]
                                 ? state_reg.tx_ones + 3'd1 : 3'd0;
              if (state_reg.tx_state == TX_FLAG2) begin
                // stay one more fall so the last flag bit is not cut short
                state_next.tx_state = TX_FLAG2;
              end else if (state_reg.tx_hold_valid) begin
                state_next.tx_state      = TX_DATA;
                state_next.tx_sh         = state_reg.tx_hold;
                state_next.tx_hold_valid = 1'b0;
              end else begin
                // an empty holding byte ends the frame early rather than sending garbage
                state_next.tx_state = TX_FLAG2;
                state_next.tx_sh    = FLAG_PATTERN;
              end
            end
          end
        end
      end
      default: state_next.tx_state = TX_IDLE;
    endcase

    // dma: receive side wins when both want the bus
    state_next.drq_out_n = ~(state_next.rx_hold_valid && !state_reg.dma_act);
    state_next.drq_in_n  = ~(!state_next.tx_hold_valid && state_next.tx_fetch_left != OTHER_RESET
                             && state_next.tx_state != TX_IDLE && state_next.tx_state != TX_FLAG2
                             && !state_reg.dma_act && state_next.drq_out_n);
    if (fall[SY_ACK] && !state_reg.dma_act) begin
      state_next.dma_act  = 1'b1;
      state_next.dma_out  = !state_reg.drq_out_n;
      state_next.addr_out = state_reg.drq_out_n ? state_reg.tx_addr : state_reg.rx_addr;
    end
    if (rise[SY_ACK] && state_reg.dma_act) begin
      state_next.dma_act = 1'b0;
      if (state_reg.dma_out) begin
        state_next.rx_hold_valid = 1'b0;
        state_next.rx_addr       = state_reg.rx_addr + 16'h0001;
      end else begin
        state_next.tx_hold       = lv[SY_DATA +: 8];
        state_next.tx_hold_valid = 1'b1;
        state_next.tx_fetch_left = state_reg.tx_fetch_left - 8'h01;
        state_next.tx_addr       = state_reg.tx_addr + 16'h0001;
      end
    end

    // event register: a new event in the clearing cycle survives
    state_next.regs[REG_IR0] = (ir_clear ? OTHER_RESET : state_next.regs[REG_IR0]) | ir_set;
    state_next.irq_n = ~((state_next.regs[REG_IR0] != OTHER_RESET)
                          && !state_next.regs[REG_CR0][CR0_NOINT]);

    // shared bus driver
    if (rd_now) begin
      state_next.data_out  = reg_view(state_reg, lv[SY_SEL +: 4]);
      state_next.data_oe_n = 1'b0;
    end else if (state_next.dma_act && state_next.dma_out) begin
      state_next.data_out  = state_reg.rx_hold;
      state_next.data_oe_n = 1'b0;
    end else begin
      state_next.data_oe_n = 1'b1;
    end

    if (!lv[SY_RESET]) begin
      state_next                    = '0;
      state_next.regs[REG_CR0]      = CR0_RESET;
      state_next.tx_state           = TX_IDLE;
      state_next.tx_bit             = 1'b1;
      state_next.rts_n              = 1'b1;
      state_next.drq_out_n          = 1'b1;
      state_next.drq_in_n           = 1'b1;
      state_next.data_oe_n          = 1'b1;
      state_next.irq_n              = 1'b1;
      state_next.wr_act             = wr_now;
      state_next.rd_act             = rd_now;
    end
  end

  always_ff @(posedge i_core_clk) begin
    if (i_rst) begin
      state_reg               <= '0;
      state_reg.regs[REG_CR0] <= CR0_RESET;
      state_reg.tx_state      <= TX_IDLE;
      state_reg.tx_bit        <= 1'b1;
      state_reg.rts_n         <= 1'b1;
      state_reg.drq_out_n     <= 1'b1;
      state_reg.drq_in_n      <= 1'b1;
      state_reg.data_oe_n     <= 1'b1;
      state_reg.irq_n         <= 1'b1;
    end else begin
      state_reg <= state_next;
    end
  end

  assign o_shared_data_lines      = state_reg.data_out;
  assign o_shared_data_lines_oe_n = state_reg.data_oe_n;
  assign o_interrupt_request_n    = state_reg.irq_n;
  assign o_dma_out_request_n      = state_reg.drq_out_n;
  assign o_dma_in_request_n       = state_reg.drq_in_n;
  assign o_dma_address_out        = state_reg.addr_out;
  assign o_serial_tx_data         = state_reg.tx_bit;
  // open collector: only ever drives low
  assign o_tx_request_n           = 1'b0;
  assign o_tx_request_oe_n        = state_reg.rts_n;

endmodule : token_net_controller
`default_nettype wire

// >>> net_checker.sv
// pin assertions for the token network controller
// assumes one core clock domain; bound to the controller by port name
`timescale 1ns/1ps
`default_nettype none
module net_checker
  import token_net_pkg::*;
(
  // clock and host side
  input wire logic        i_core_clk,
  input wire logic        i_rst,
  input wire logic        i_chip_select_n,
  input wire logic        i_read_strobe_n,
  input wire logic [3:0]  i_register_select_in,
  input wire logic        i_dma_acknowledge_n,
  input wire logic        o_shared_data_lines_oe_n,
  input wire logic        o_interrupt_request_n,
  input wire logic        o_dma_out_request_n,
  input wire logic        o_dma_in_request_n,
  input wire logic [15:0] o_dma_address_out,
  // modem side
  input wire logic        i_serial_tx_clock_n,
  input wire logic        i_clear_to_send_n,
  input wire logic        o_serial_tx_data,
  input wire logic        o_tx_request_oe_n
);
  logic [2:0] gap_reg;
  logic [3:0] fall_reg;
  logic       txclk_reg;
  wire logic  rd_on = !i_chip_select_n && !i_read_strobe_n;
  // saturating counts: cycles since a bus access, since a tx clock fall
  always_ff @(posedge i_core_clk) begin
    txclk_reg <= i_serial_tx_clock_n;
    gap_reg  <= (i_rst || rd_on || !i_dma_acknowledge_n) ? 3'h0 : gap_reg + 3'(gap_reg != 3'h7);
    fall_reg <= (i_rst || (txclk_reg && !i_serial_tx_clock_n)) ? 4'h0 : fall_reg + 4'(fall_reg != 4'hf);
  end
  default clocking cb @(posedge i_core_clk); endclocking
  default disable iff (i_rst);
  a_reset_outputs: assert property ($past(i_rst) |-> o_shared_data_lines_oe_n && o_interrupt_request_n
    && o_dma_out_request_n && o_dma_in_request_n && o_tx_request_oe_n && o_serial_tx_data
    && o_dma_address_out == 16'h0000) else $error("outputs not idle after reset");
  a_read_drives: assert property (rd_on [*5] |-> !o_shared_data_lines_oe_n)
    else $error("register read not driven");
  a_bus_floats: assert property (!o_shared_data_lines_oe_n |-> gap_reg <= 3'h5)
    else $error("data bus driven without access");
  a_in_floats: assert property ((!o_dma_in_request_n && !i_dma_acknowledge_n) ##1
    !i_dma_acknowledge_n [*5] |-> o_shared_data_lines_oe_n) else $error("bus driven in dma input");
  a_out_drives: assert property ((!o_dma_out_request_n && !i_dma_acknowledge_n) ##1
    !i_dma_acknowledge_n [*5] |-> !o_shared_data_lines_oe_n) else $error("dma output not driven");
  a_req_drops: assert property (!i_dma_acknowledge_n [*6] |-> o_dma_out_request_n && o_dma_in_request_n)
    else $error("dma request held after acknowledge");
  a_irq_release: assert property ((rd_on && i_register_select_in == REG_IR0) [*4] ##1 !rd_on
    |-> ##[2:6] o_interrupt_request_n) else $error("interrupt kept after event read");
  a_tx_on_fall: assert property ($changed(o_serial_tx_data) && !o_tx_request_oe_n
    |-> fall_reg inside {[4'h1:4'h5]}) else $error("tx data moved off the falling edge");
  a_tx_after_cts: assert property ($fell(o_serial_tx_data) |-> !$past(i_clear_to_send_n, 4))
    else $error("transmit without clear to send");
  a_rts_held: assert property ($fell(o_serial_tx_data) |-> !o_tx_request_oe_n)
    else $error("transmit without request");
  cover property (!o_dma_out_request_n && !i_dma_acknowledge_n);
  cover property (!o_dma_in_request_n && !i_dma_acknowledge_n);
  cover property ($fell(o_interrupt_request_n));
endmodule : net_checker
bind token_net_controller net_checker chk_i (.*);
`default_nettype wire

// >>> modem_model.sv
// modem model: 1x link clocks, clear to send, signal quality, frame capture
// assumes the request line arrives already resolved with its pull-up
`timescale 1ns/1ps
`default_nettype none
module modem_model (
  // from the controller
  input  wire logic i_tx_data,
  input  wire logic i_rts_n,
  // to the controller
  output logic      o_rx_clk,
  output logic      o_rx_data,
  output logic      o_tx_clk_n,
  output logic      o_cts_n,
  output logic      o_sq_n
);
  logic [31:0] cap_reg = 32'h0000_0000;
  initial {o_rx_clk, o_rx_data, o_tx_clk_n, o_cts_n, o_sq_n} = 5'h0f;
  // tx clock stands high outside frames
  always begin : tx_side
    wait (!i_rts_n);
    #307 o_cts_n = 1'b0;
    while (!i_rts_n) begin
      #80 o_tx_clk_n = 1'b0;
      #80 o_tx_clk_n = 1'b1;
      cap_reg = {i_tx_data, cap_reg[31:1]};
    end
    #640 o_cts_n = 1'b1;
  end
  task automatic rx_frame(input logic [7:0] a, input logic [7:0] d, input logic bad);
    logic [31:0] f;
    f = {8'h7e, d, a, 8'h7e};
    o_sq_n = bad;
    #7;
    for (int i = 0; i < 32; i++) begin
      o_rx_data = f[i];
      #80 o_rx_clk = 1'b1;
      #80 o_rx_clk = 1'b0;
    end
    o_rx_data = 1'b1;
    // quality stays put past the closing flag so the verdict sees it
    #400 o_sq_n = 1'b1;
  endtask : rx_frame
endmodule : modem_model
`default_nettype wire

// >>> tb_top.sv
// bench for the token network controller: host port, dma service, modem link
// assumes package, controller, checker and modem model are compiled first
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  import token_net_pkg::*;
  logic        i_core_clk = 1'b0, i_rst = 1'b1, i_master_reset_n = 1'b0, i_dma_acknowledge_n = 1'b1;
  logic        i_chip_select_n = 1'b1, i_read_strobe_n = 1'b1, i_write_strobe_n = 1'b1;
  logic [3:0]  i_register_select_in = 4'h0;
  logic [7:0]  hd = 8'h00;
  logic [7:0]  o_shared_data_lines;
  logic [15:0] o_dma_address_out;
  logic        o_shared_data_lines_oe_n, o_interrupt_request_n, o_dma_out_request_n, o_dma_in_request_n;
  logic        o_serial_tx_data, o_tx_request_n, o_tx_request_oe_n, i_serial_rx_clock, i_serial_rx_data;
  logic        i_serial_tx_clock_n, i_clear_to_send_n, i_signal_quality_n;
  int          bad_count = 0, check_count = 0, seed = 11766;
  wire logic [7:0] i_shared_data_lines = o_shared_data_lines_oe_n ? hd : o_shared_data_lines;
  wire logic       rts_n = o_tx_request_oe_n | o_tx_request_n;
  modem_model m (.i_tx_data(o_serial_tx_data), .i_rts_n(rts_n), .o_rx_clk(i_serial_rx_clock),
    .o_rx_data(i_serial_rx_data), .o_tx_clk_n(i_serial_tx_clock_n), .o_cts_n(i_clear_to_send_n),
    .o_sq_n(i_signal_quality_n));
  token_net_controller dut (.*);
  always #10 i_core_clk = ~i_core_clk;
  task automatic tick(input int n);
    repeat (n) @(posedge i_core_clk);
    #2;
  endtask : tick
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    check_count++;
    if (got !== exp) begin
      bad_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk
  task automatic wr(input logic [3:0] s, input logic [7:0] d);
    i_register_select_in = s;
    hd = d;
    {i_chip_select_n, i_write_strobe_n} = 2'b00;
    tick(4);
    {i_chip_select_n, i_write_strobe_n} = 2'b11;
    tick(2);
    hd = ~d;
    tick(2);
  endtask : wr
  task automatic rc(input logic [3:0] s, input logic [7:0] e);
    i_register_select_in = s;
    {i_chip_select_n, i_read_strobe_n} = 2'b00;
    tick(5);
    chk(i_shared_data_lines, e);
    {i_chip_select_n, i_read_strobe_n} = 2'b11;
    tick(5);
  endtask : rc
  task automatic dma(input logic [7:0] d, output logic [7:0] q, output logic [15:0] a, output logic o);
    repeat (4000) if (o_dma_out_request_n && o_dma_in_request_n) tick(1);
    o = !o_dma_out_request_n;
    hd = d;
    i_dma_acknowledge_n = 1'b0;
    tick(6);
    q = i_shared_data_lines;
    a = o_dma_address_out;
    i_dma_acknowledge_n = 1'b1;
    tick(2);
    hd = ~d;
    tick(2);
  endtask : dma
  task automatic end_of_test();
    $display("checks %0d mismatches %0d", check_count, bad_count);
    if (bad_count == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : end_of_test
  initial begin : main
    logic [7:0]  v, ma, d, q;
    logic [15:0] a, base;
    logic        o, hit;
    tick(8);
    i_rst = 1'b0;
    i_master_reset_n = 1'b1;
    tick(6);
    chk({o_shared_data_lines_oe_n, o_interrupt_request_n, o_dma_out_request_n, rts_n}, 4'hf);
    rc(REG_CR0, CR0_RESET);
    for (int s = 1; s < 14; s++) begin
      v = 8'($random(seed));
      wr(4'(s), v);
      if (s < 2 || s == 3 || s > 5) rc(4'(s), (s > 7 || s == 1) ? v : 8'h00);
    end
    i_master_reset_n = 1'b0;
    tick(4);
    i_master_reset_n = 1'b1;
    tick(6);
    rc(REG_CR1, 8'h00);
    rc(REG_CR0, CR0_RESET);
    ma = (8'($random(seed)) & 8'h77) | 8'h01;
    base = 16'($random(seed));
    wr(REG_MA, ma);
    wr(REG_CBPH, base[15:8]);
    wr(REG_CBPL, base[7:0]);
    wr(REG_CR0, 8'h60);
    repeat (500) if (o_interrupt_request_n) tick(1);
    chk(o_interrupt_request_n, 1'b0);
    rc(REG_IR0, 8'h01);
    chk(o_interrupt_request_n, 1'b1);
    rc(REG_IR0, 8'h00);
    rc(REG_FIRST_STATUS, 8'h00);
    rc(REG_SR1, 8'h7f);
    rc(REG_SR2, 8'h01);
    for (int f = 0; f < 2; f++) begin
      d = 8'($random(seed)) & 8'h77;
      fork
        m.rx_frame(ma, d, f[0]);
        begin
          dma(8'h00, q, a, o);
          chk({o, q}, {1'b1, ma});
          if (f == 0) chk(a, base);
          dma(8'h00, q, a, o);
          chk({o, q}, {1'b1, d});
          if (f == 0) chk(a, base + 16'h0001);
        end
      join
      tick(20);
      rc(REG_IR0, f ? 8'h00 : 8'h08);
    end
    rc(REG_CTR0, 8'h01);
    v = 8'($random(seed)) & 8'h77;
    wr(REG_TXLT, 8'h01);
    dma(v, q, a, o);
    chk(o, 1'b0);
    chk(a, base + TX_AREA_OFFSET);
    repeat (300) if (rts_n) tick(1);
    chk(rts_n, 1'b0);
    repeat (4000) if (!rts_n) tick(1);
    tick(60);
    hit = 1'b0;
    for (int k = 0; k < 9; k++) hit |= (m.cap_reg[k +: 24] === {8'h7e, v, 8'h7e});
    chk(hit, 1'b1);
    rc(REG_IR0, 8'h10);
    end_of_test();
  end
  initial begin : watchdog
    #1_000_000;
    bad_count++;
    end_of_test();
  end
endmodule : tb_top
`default_nettype wire
